//--- logic/pocsl_pkg.sv
// constants and carrier types for the phase overcurrent stage logic
package pocsl_pkg;
    // ****************************************
    // widths and codes
    // ****************************************
    localparam int CUR_W = 16;
    localparam int TMR_W = 20;
    localparam logic [1:0] STAGE_LOW   = 2'h1;
    localparam logic [1:0] STAGE_HIGH  = 2'h2;
    localparam logic [1:0] STAGE_SUPER = 2'h3;
    localparam logic [1:0] STAGE_NONE  = 2'h0;
    // current in per-unit of rated current, 8 fraction bits
    localparam logic [CUR_W-1:0] INV_CLAMP = 16'h0280;  // 2.5 x rated
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ       = 20000000;
    localparam int ENERG_WIN_MS = 60;
    localparam int ENERG_WIN_CYC = (CLK_HZ / 1000) * ENERG_WIN_MS;
    // curve select: 0 definite, 1..7 inverse, curve set by the low two bits
    localparam logic [2:0] CURVE_DEFINITE = 3'h0;
    localparam logic [2:0] CURVE_MAX      = 3'h6;

    typedef struct packed {
        logic [CUR_W-1:0] phA;
        logic [CUR_W-1:0] phB;
        logic [CUR_W-1:0] phC;
    } pocsl_phase_t;

    typedef struct packed {
        logic lowStart;
        logic highStart;
        logic superStart;
        logic lowOperate;
        logic highOperate;
        logic superOperate;
    } pocsl_sig_t;
endpackage : pocsl_pkg

//--- logic/pocsl_stage_logic.sv
// three-stage phase overcurrent decision logic with relay routing
`timescale 1ns/10ps
// Overview of operation
// - three independent stages, each with own start value and operate time
// - stage starts when any phase current exceeds its start value
// - start gives routable start signal and a numeric start code
// - definite time: operate once overcurrent outlasts set operate time
// - low-set inverse time: delay derived from measured current level
// - low-set mode and one of four curves chosen by curve switchgroup
// - inverse mode clamps low-set start value to 2.5 times rated
// - low and high stages inhibited by selected external blocking inputs
// - optional doubling of high-set start value during energising
// - energising when currents rise below 0.12 to above 1.5 within 60 ms
// - energising ends when currents drop below 1.25 times low start
// - high and superhigh stages individually disableable, shown as dashes
// - optional suppression of low inverse time while upper stages started
// - every start and operate signal routable to any output relay
// - permanent internal fault raises alarm and blocks other relay outputs
module pocsl_stage_logic #(
    parameter int RELAYS = 8,
    parameter int ENERG_WIN = pocsl_pkg::ENERG_WIN_CYC
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          reset,
    // measured currents
    input  wire pocsl_pkg::pocsl_phase_t       phaseCur,
    // settings
    input  wire logic [pocsl_pkg::CUR_W-1:0]   lowStartSet,
    input  wire logic [pocsl_pkg::CUR_W-1:0]   highStartSet,
    input  wire logic [pocsl_pkg::CUR_W-1:0]   superStartSet,
    input  wire logic [pocsl_pkg::TMR_W-1:0]   lowOpTime,
    input  wire logic [pocsl_pkg::TMR_W-1:0]   highOpTime,
    input  wire logic [pocsl_pkg::TMR_W-1:0]   superOpTime,
    input  wire logic [2:0]                    curve_selection_switchgroup,
    input  wire logic                          highEnable,
    input  wire logic                          superEnable,
    input  wire logic                          doubleOnEnergise,
    input  wire logic                          inhibitInvOnUpper,
    // blocking: bits 0..2 pick inputs for low, bits 3..5 for high
    input  wire logic [5:0]                    blocking_switchgroups,
    input  wire logic                          block_input_one,
    input  wire logic                          block_input_two,
    input  wire logic                          remote_reset_block_input_three,
    // routing: one mask per signal of pocsl_sig_t
    input  wire logic [5:0][RELAYS-1:0]        routeMatrix,
    input  wire logic                          internalFault,
    // outputs
    output logic                               startAny,
    output pocsl_pkg::pocsl_sig_t              stageSig,
    output logic [1:0]                         startCode,
    output logic                               highDashes,
    output logic                               superDashes,
    output logic                               energiseActive,
    output logic [RELAYS-1:0]                  relayOut,
    output logic                               alarmOut
);
    // ****************************************
    // comparisons
    // ****************************************
    logic [pocsl_pkg::CUR_W-1:0] maxCur;
    logic [pocsl_pkg::CUR_W+1:0] lowEff;
    logic [pocsl_pkg::CUR_W+1:0] highEff;
    logic                        inverseMode;
    logic                        blkLow;
    logic                        blkHigh;
    logic                        overLow;
    logic                        overHigh;
    logic                        overSuper;
    logic [2:0]                  blkIn;
    logic                        energNext;

    always_comb
    begin
        maxCur = phaseCur.phA;
        if (phaseCur.phB > maxCur)
            maxCur = phaseCur.phB;
        if (phaseCur.phC > maxCur)
            maxCur = phaseCur.phC;
    end

    assign inverseMode = (curve_selection_switchgroup != pocsl_pkg::CURVE_DEFINITE);
    assign lowEff = (inverseMode && lowStartSet > pocsl_pkg::INV_CLAMP) ?
                    {2'h0, pocsl_pkg::INV_CLAMP} : {2'h0, lowStartSet};
    // doubled threshold already applies in the cycle energising is declared
    assign highEff = (doubleOnEnergise && energNext) ?
                     {1'h0, highStartSet, 1'h0} : {2'h0, highStartSet};
    assign blkIn = {remote_reset_block_input_three, block_input_two, block_input_one};
    assign blkLow  = |(blkIn & blocking_switchgroups[2:0]);
    assign blkHigh = |(blkIn & blocking_switchgroups[5:3]);
    assign overLow   = ({2'h0, maxCur} > lowEff) && !blkLow;
    assign overHigh  = ({2'h0, maxCur} > highEff) && highEnable && !blkHigh;
    assign overSuper = (maxCur > superStartSet) && superEnable;

    // ****************************************
    // energising detection
    // ****************************************
    logic [pocsl_pkg::CUR_W+7:0] cur100;
    logic [pocsl_pkg::CUR_W+7:0] lowX;
    logic                        belowLow12;
    logic                        aboveLow150;
    logic                        belowLow125;
    logic [23:0]                 winCnt_reg;

    assign cur100 = {8'h00, maxCur} * 24'h000064;
    assign lowX   = {8'h00, lowStartSet};
    assign belowLow12  = cur100 < lowX * 24'h00000C;
    assign aboveLow150 = cur100 > lowX * 24'h000096;
    assign belowLow125 = cur100 < lowX * 24'h00007D;

    // window opens while current is low, counts down after it rises
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            winCnt_reg <= 24'h000000;
        else if (belowLow12)
            winCnt_reg <= 24'(ENERG_WIN);
        else if (winCnt_reg != 24'h000000)
            winCnt_reg <= winCnt_reg - 24'h000001;
    end

    always_comb
    begin
        energNext = energiseActive;
        if (!energiseActive && aboveLow150 && winCnt_reg != 24'h000000)
            energNext = 1'b1;
        else if (energiseActive && belowLow125)
            energNext = 1'b0;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            energiseActive <= 1'b0;
        else
            energiseActive <= energNext;
    end

    // ****************************************
    // operate timers
    // ****************************************
    logic [2:0]                       overVec;
    logic [2:0][pocsl_pkg::TMR_W-1:0] limit;
    logic [2:0][pocsl_pkg::TMR_W-1:0] tmr_reg;
    logic [2:0]                       opr_reg;
    logic [2:0]                       st_reg;
    logic [pocsl_pkg::TMR_W-1:0]      invStep;
    logic                             lowInvHold;
    logic [pocsl_pkg::CUR_W+1:0]      ratio;

    assign overVec = {overSuper, overHigh, overLow};
    // inverse time: advance faster as current grows past start value
    assign ratio = ({2'h0, maxCur} << curve_selection_switchgroup[1:0]) / (lowEff | 18'h00001);
    assign invStep = (ratio > 18'h00001) ? pocsl_pkg::TMR_W'(ratio) : 20'h00001;
    assign lowInvHold = inhibitInvOnUpper && inverseMode && (st_reg[1] || st_reg[2]);
    assign limit = {superOpTime, highOpTime, lowOpTime};

    for (genvar s = 0; s < 3; s++)
    begin : g_stage
        logic [pocsl_pkg::TMR_W-1:0] step;
        assign step = (s == 0 && inverseMode) ? invStep : 20'h00001;

        always_ff @(posedge sys_clk or posedge reset)
        begin
            if (reset)
            begin
                tmr_reg[s] <= '0;
                st_reg[s]  <= 1'b0;
                opr_reg[s] <= 1'b0;
            end
            else if (!overVec[s])
            begin
                tmr_reg[s] <= '0;
                st_reg[s]  <= 1'b0;
                opr_reg[s] <= 1'b0;
            end
            else
            begin
                st_reg[s] <= 1'b1;
                if (s == 0 && lowInvHold)
                    tmr_reg[s] <= tmr_reg[s];
                else if (tmr_reg[s] >= limit[s])
                    opr_reg[s] <= 1'b1;
                else
                    tmr_reg[s] <= tmr_reg[s] + step;
            end
        end
    end

    // ****************************************
    // outputs and routing
    // ****************************************
    pocsl_pkg::pocsl_sig_t sigNow;
    assign sigNow = '{lowStart: st_reg[0], highStart: st_reg[1], superStart: st_reg[2],
                      lowOperate: opr_reg[0], highOperate: opr_reg[1],
                      superOperate: opr_reg[2]};

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            stageSig  <= '0;
            startAny  <= 1'b0;
            startCode <= pocsl_pkg::STAGE_NONE;
        end
        else
        begin
            stageSig <= sigNow;
            startAny <= |st_reg;
            if (st_reg[2])
                startCode <= pocsl_pkg::STAGE_SUPER;
            else if (st_reg[1])
                startCode <= pocsl_pkg::STAGE_HIGH;
            else if (st_reg[0])
                startCode <= pocsl_pkg::STAGE_LOW;
            else
                startCode <= pocsl_pkg::STAGE_NONE;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            highDashes  <= 1'b0;
            superDashes <= 1'b0;
        end
        else
        begin
            highDashes  <= !highEnable;
            superDashes <= !superEnable;
        end
    end

    logic [RELAYS-1:0] routed;
    always_comb
    begin
        routed = '0;
        for (int i = 0; i < 6; i++)
            if (sigNow[5-i])
                routed = routed | routeMatrix[i];
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            relayOut <= '0;
            alarmOut <= 1'b0;
        end
        else
        begin
            relayOut <= internalFault ? '0 : routed;
            alarmOut <= internalFault;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_FAULT_BLOCKS: assert property (@(posedge sys_clk) disable iff (reset)
        internalFault |=> (relayOut == '0) && alarmOut)
        else $error("relay outputs not blocked on fault");
    AST_DROP_CLEARS: assert property (@(posedge sys_clk) disable iff (reset)
        !overVec[0] |=> !st_reg[0] && !opr_reg[0] && tmr_reg[0] == '0)
        else $error("low stage not cleared on drop");
    AST_SUPER_DISABLED: assert property (@(posedge sys_clk) disable iff (reset)
        !superEnable [*2] |-> !st_reg[2] && !opr_reg[2])
        else $error("disabled superhigh stage active");
    AST_START_FOLLOWS: assert property (@(posedge sys_clk) disable iff (reset)
        overVec[1] |=> st_reg[1])
        else $error("high stage failed to start");
    AST_OPERATE_CAUSE: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(opr_reg[1]) |-> $past(tmr_reg[1]) >= $past(highOpTime))
        else $error("high stage operated early");
    AST_ENERG_END: assert property (@(posedge sys_clk) disable iff (reset)
        energiseActive && belowLow125 |=> !energiseActive)
        else $error("energising did not end");
    AST_BLOCK_LOW: assert property (@(posedge sys_clk) disable iff (reset)
        blkLow |=> !st_reg[0])
        else $error("blocked low stage started");
    AST_CODE: assert property (@(posedge sys_clk) disable iff (reset)
        st_reg[2] |=> startCode == pocsl_pkg::STAGE_SUPER)
        else $error("wrong start code");
endmodule : pocsl_stage_logic

//--- verif/pocsl_relay_partner.sv
// model of the output relay contacts and the external blocking lines
`timescale 1ns/10ps
module pocsl_relay_partner (
    // clock
    input  wire logic        sys_clk,
    // bench side
    input  wire logic [2:0]  blkCmd,
    output logic [7:0]       relaySeen,
    // block side
    input  wire logic [7:0]  relayOut,
    output logic             block_input_one,
    output logic             block_input_two,
    output logic             remote_reset_block_input_three
);
    // contacts follow the relay drive one cycle late
    always_ff @(posedge sys_clk)
    begin
        relaySeen <= relayOut;
        {remote_reset_block_input_three, block_input_two, block_input_one} <= blkCmd;
    end
endmodule : pocsl_relay_partner

//--- verif/pocsl_stage_logic_tb.sv
// self-checking bench for the phase overcurrent stage logic
`timescale 1ns/10ps
module pocsl_stage_logic_tb;
    logic                     sys_clk, reset, highEnable, superEnable, doubleOnEnergise;
    logic                     internalFault, startAny, highDashes, superDashes, inhibitInv;
    logic                     energiseActive, alarmOut, blkOne, blkTwo, blkThree;
    pocsl_pkg::pocsl_phase_t  phaseCur;
    pocsl_pkg::pocsl_sig_t    stageSig;
    logic [15:0]              lowStartSet, highStartSet, superStartSet;
    logic [2:0]               curveSel, blkCmd;
    logic [5:0]               blockSel;
    logic [5:0][7:0]          routeMatrix;
    logic [1:0]               startCode;
    logic [7:0]               relayOut, relaySeen;
    int                       errors, n_tests;

    pocsl_stage_logic #(.RELAYS(8), .ENERG_WIN(50)) i_pocsl_stage_logic (
        .sys_clk(sys_clk), .reset(reset), .phaseCur(phaseCur),
        .lowStartSet(lowStartSet), .highStartSet(highStartSet),
        .superStartSet(superStartSet), .lowOpTime(20'h00014), .highOpTime(20'h0000A),
        .superOpTime(20'h00005), .curve_selection_switchgroup(curveSel),
        .highEnable(highEnable), .superEnable(superEnable),
        .doubleOnEnergise(doubleOnEnergise), .inhibitInvOnUpper(inhibitInv),
        .blocking_switchgroups(blockSel), .block_input_one(blkOne),
        .block_input_two(blkTwo), .remote_reset_block_input_three(blkThree),
        .routeMatrix(routeMatrix), .internalFault(internalFault),
        .startAny(startAny), .stageSig(stageSig), .startCode(startCode),
        .highDashes(highDashes), .superDashes(superDashes),
        .energiseActive(energiseActive), .relayOut(relayOut), .alarmOut(alarmOut));

    pocsl_relay_partner i_pocsl_relay_partner (
        .sys_clk(sys_clk), .blkCmd(blkCmd), .relaySeen(relaySeen), .relayOut(relayOut),
        .block_input_one(blkOne), .block_input_two(blkTwo),
        .remote_reset_block_input_three(blkThree));

    initial
    begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask : tick

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic setCur(input logic [15:0] c, input int n);
        @(posedge sys_clk);
        phaseCur <= {16'h0000, c, 16'h0000};
        tick(n);
    endtask : setCur

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic t_high();
        setCur(16'h0200, 3);
        chk("startCode", 16'h0002, startCode);
        chk("highOperate", 16'h0000, stageSig.highOperate);
        tick(12);
        chk("highOperate", 16'h0001, stageSig.highOperate);
        setCur(16'h0500, 9);
        chk("startCode", 16'h0003, startCode);
        chk("superOperate", 16'h0001, stageSig.superOperate);
        setCur(16'h0000, 3);
        chk("startAny", 16'h0000, startAny);
    endtask : t_high

    task automatic t_drop();
        setCur(16'h0120, 3);
        chk("lowStart", 16'h0001, stageSig.lowStart);
        chk("startCode", 16'h0001, startCode);
        tick(5);
        setCur(16'h0000, 3);
        chk("lowStart", 16'h0000, stageSig.lowStart);
        setCur(16'h0120, 15);
        chk("lowOperate", 16'h0000, stageSig.lowOperate);
        tick(10);
        chk("lowOperate", 16'h0001, stageSig.lowOperate);
        setCur(16'h0000, 3);
    endtask : t_drop

    task automatic t_block();
        @(posedge sys_clk);
        blockSel <= 6'h02;
        blkCmd <= 3'h2;
        setCur(16'h0120, 4);
        chk("lowStart", 16'h0000, stageSig.lowStart);
        @(posedge sys_clk);
        blkCmd <= 3'h0;
        tick(5);
        chk("lowStart", 16'h0001, stageSig.lowStart);
        @(posedge sys_clk);
        highEnable <= 1'h0;
        setCur(16'h0200, 3);
        chk("highDashes", 16'h0001, highDashes);
        chk("highStart", 16'h0000, stageSig.highStart);
        @(posedge sys_clk);
        highEnable <= 1'h1;
        setCur(16'h0000, 3);
    endtask : t_block

    task automatic t_energ();
        @(posedge sys_clk);
        doubleOnEnergise <= 1'h1;
        setCur(16'h0200, 5);
        chk("energiseActive", 16'h0001, energiseActive);
        chk("highStart", 16'h0000, stageSig.highStart);
        // dwell past the energising window so the next rise is not inrush
        setCur(16'h0130, 60);
        chk("energiseActive", 16'h0000, energiseActive);
        setCur(16'h0200, 4);
        chk("highStart", 16'h0001, stageSig.highStart);
        chk("energiseActive", 16'h0000, energiseActive);
        @(posedge sys_clk);
        doubleOnEnergise <= 1'h0;
        setCur(16'h0000, 3);
    endtask : t_energ

    task automatic t_inv();
        @(posedge sys_clk);
        curveSel <= 3'h1;
        lowStartSet <= 16'h0400;
        setCur(16'h0300, 4);
        chk("lowStart", 16'h0001, stageSig.lowStart);
        tick(12);
        chk("lowOperate", 16'h0001, stageSig.lowOperate);
        setCur(16'h0000, 3);
    endtask : t_inv

    task automatic t_upper();
        @(posedge sys_clk);
        inhibitInv <= 1'h1;
        setCur(16'h0300, 16);
        chk("lowStart", 16'h0001, stageSig.lowStart);
        chk("lowOperate", 16'h0000, stageSig.lowOperate);
        chk("highOperate", 16'h0001, stageSig.highOperate);
        @(posedge sys_clk);
        inhibitInv <= 1'h0;
        setCur(16'h0000, 3);
        @(posedge sys_clk);
        superEnable <= 1'h0;
        superStartSet <= 16'h0100;
        setCur(16'h0200, 8);
        chk("superDashes", 16'h0001, superDashes);
        chk("superStart", 16'h0000, stageSig.superStart);
        @(posedge sys_clk);
        superEnable <= 1'h1;
        tick(3);
        chk("superStart", 16'h0001, stageSig.superStart);
        chk("startCode", 16'h0003, startCode);
        @(posedge sys_clk);
        superStartSet <= 16'h0400;
        setCur(16'h0000, 3);
    endtask : t_upper

    task automatic t_route();
        @(posedge sys_clk);
        routeMatrix[1] <= 8'h08;
        routeMatrix[4] <= 8'h80;
        setCur(16'h0200, 4);
        chk("relaySeen", 16'h0008, relaySeen);
        tick(12);
        chk("relaySeen", 16'h0088, relaySeen);
        @(posedge sys_clk);
        internalFault <= 1'h1;
        tick(3);
        chk("relayOut", 16'h0000, relayOut);
        chk("alarmOut", 16'h0001, alarmOut);
    endtask : t_route

    initial
    begin
        errors = 0;
        n_tests = 0;
        reset = 1'h1;
        phaseCur = '0;
        lowStartSet = 16'h0100;
        highStartSet = 16'h0180;
        curveSel = 3'h0;
        superStartSet = 16'h0400;
        inhibitInv = 1'h0;
        {highEnable, superEnable, doubleOnEnergise, internalFault} = 4'hC;
        blockSel = 6'h00;
        blkCmd = 3'h0;
        routeMatrix = '0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'h0;
        tick(3);
        t_high();
        t_drop();
        t_block();
        t_energ();
        t_inv();
        t_upper();
        t_route();
        give_verdict();
    end

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        give_verdict();
    end
endmodule : pocsl_stage_logic_tb
